// ==== common/irq_ctrl_map.vh ====
// Purpose: Register offsets, field positions, reset values for the interrupt control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Offsets are chosen for this block; byte addresses.
`ifndef IRQ_CTRL_MAP_VH
`define IRQ_CTRL_MAP_VH
`define OFS_INTERRUPT_CONTROL 8'h00
`define OFS_INTERRUPT_CONTROL_TWO 8'h04
`define OFS_INTERRUPT_CONTROL_THREE 8'h08
`define OFS_PERIPHERAL_FLAGS_ONE 8'h0c
`define OFS_PERIPHERAL_ENABLES 8'h10
`define OFS_PERIPHERAL_PRIORITY 8'h14
`define OFS_CORE_CONTROL 8'h18
`define RST_INTERRUPT_CONTROL 8'h00
`define RST_INTERRUPT_CONTROL_TWO 8'hf5
`define RST_INTERRUPT_CONTROL_THREE 8'hc0
`define RST_PERIPHERAL_FLAGS_ONE 8'h00
`define RST_PERIPHERAL_ENABLES 8'h00
`define RST_PERIPHERAL_PRIORITY 8'hff
`define MASK_INTERRUPT_CONTROL_TWO 8'hf5
`define MASK_INTERRUPT_CONTROL_THREE 8'hdb
`define MASK_PERIPHERAL_FLAGS_SW 8'hcf
`define BIT_GLOBAL_OR_HIGH 7
`define BIT_PERIPH_OR_LOW 6
`define BIT_T0_ENABLE 5
`define BIT_EXT0_ENABLE 4
`define BIT_PORT_CHANGE_ENABLE 3
`define BIT_T0_FLAG 2
`define BIT_EXT0_FLAG 1
`define BIT_PORT_CHANGE_FLAG 0
`define BIT_PULLUP_DISABLE 7
`define BIT_EXT0_EDGE 6
`define BIT_EXT1_EDGE 5
`define BIT_EXT2_EDGE 4
`define BIT_T0_PRIORITY 2
`define BIT_PORT_CHANGE_PRIORITY 0
`define BIT_EXT2_PRIORITY 7
`define BIT_EXT1_PRIORITY 6
`define BIT_EXT2_ENABLE 4
`define BIT_EXT1_ENABLE 3
`define BIT_EXT2_FLAG 1
`define BIT_EXT1_FLAG 0
`define BIT_PARALLEL_FLAG 7
`define BIT_CONVERSION_FLAG 6
`define BIT_RX_FLAG 5
`define BIT_TX_FLAG 4
`define BIT_SYNC_SERIAL_FLAG 3
`define BIT_CAPTURE_FLAG 2
`define BIT_TIMER2_FLAG 1
`define BIT_TIMER1_FLAG 0
`define BIT_PRIORITY_MODE 7
`define VECTOR_HIGH 24'h000008
`define VECTOR_LOW 24'h000018
`endif

// ==== rtl/interrupt_enable_flag_priority.v ====
// Purpose: Interrupt enable, flag and priority logic with APB register access.
// Assumes: Event inputs are one-cycle pulses synchronous to clk; pins synchronous to clk.
// Notes: APB slave answers with zero wait states; unmapped reads return zero with pslverr.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "irq_ctrl_map.vh"

module interrupt_enable_flag_priority (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire timer0_overflow,
  input wire [2:0] ext_pins,
  input wire [3:0] upper_port_pins,
  input wire port_b_data_read,
  input wire [7:0] port_b_latch,
  input wire conversion_done,
  input wire receive_buffer_full,
  input wire transmit_buffer_empty,
  input wire sync_serial_done,
  input wire capture_compare_event,
  input wire capture_compare_pwm_mode,
  input wire timer2_match,
  input wire timer1_overflow,
  input wire parallel_port_done,
  input wire small_package,
  input wire irq_ack,
  input wire irq_return,
  output reg irq_request,
  output reg [23:0] irq_vector,
  output reg [7:0] port_b_pullup_en
);

  localparam ST_IDLE = 2'h1;
  localparam ST_SERVICE = 2'h2;

  reg [7:0] ctl_r;
  reg [7:0] ctl2_r;
  reg [7:0] ctl3_r;
  reg [7:0] pflags_r;
  reg [7:0] pen_r;
  reg [7:0] pprio_r;
  reg priority_mode_enable_r;
  reg [1:0] state_r;
  reg serv_high_r;
  reg [2:0] ext_prev_r;
  reg [3:0] port_snap_r;
  reg [7:0] rdata_nxt;
  reg addr_ok;
  reg [7:0] ctl_nxt;
  reg [7:0] ctl3_nxt;
  reg [1:0] state_nxt;
  reg serv_high_nxt;
  reg irq_request_nxt;
  reg [23:0] irq_vector_nxt;
  reg drop_high;
  reg drop_low;
  reg raise_high;
  reg raise_low;
  wire [7:0] pflags_nxt;

  // Register bus decode; a write lands only in the access cycle.
  wire setup = psel && !penable;
  wire wr = psel && penable && pwrite;
  wire [7:0] wd = pwdata[7:0];
  wire wr_ctl = wr && (paddr == `OFS_INTERRUPT_CONTROL);
  wire wr_ctl2 = wr && (paddr == `OFS_INTERRUPT_CONTROL_TWO);
  wire wr_ctl3 = wr && (paddr == `OFS_INTERRUPT_CONTROL_THREE);
  wire wr_pf = wr && (paddr == `OFS_PERIPHERAL_FLAGS_ONE);
  wire wr_pen = wr && (paddr == `OFS_PERIPHERAL_ENABLES);
  wire wr_pprio = wr && (paddr == `OFS_PERIPHERAL_PRIORITY);
  wire wr_core = wr && (paddr == `OFS_CORE_CONTROL);

  // Edge detect per external pin, polarity from the edge select bits.
  wire [2:0] edge_sel = {ctl2_r[`BIT_EXT2_EDGE], ctl2_r[`BIT_EXT1_EDGE],
                         ctl2_r[`BIT_EXT0_EDGE]};
  wire [2:0] ext_evt;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_edge
      assign ext_evt[g] = edge_sel[g] ? (ext_pins[g] && !ext_prev_r[g])
                                      : (!ext_pins[g] && ext_prev_r[g]);
    end
  endgenerate

  // The mismatch is against the value last latched by a port read, so it persists.
  wire mismatch = (upper_port_pins != port_snap_r);

  // Peripheral event pulses; the capture flag ignores events in PWM mode.
  wire [7:0] p_evt;
  assign p_evt[`BIT_PARALLEL_FLAG] = parallel_port_done && !small_package;
  assign p_evt[`BIT_CONVERSION_FLAG] = conversion_done;
  assign p_evt[`BIT_RX_FLAG] = 1'h0;
  assign p_evt[`BIT_TX_FLAG] = 1'h0;
  assign p_evt[`BIT_SYNC_SERIAL_FLAG] = sync_serial_done;
  assign p_evt[`BIT_CAPTURE_FLAG] = capture_compare_event && !capture_compare_pwm_mode;
  assign p_evt[`BIT_TIMER2_FLAG] = timer2_match;
  assign p_evt[`BIT_TIMER1_FLAG] = timer1_overflow;

  wire [7:0] pf_live = {pflags_r[7:6], receive_buffer_full, transmit_buffer_empty,
                        pflags_r[3:0]};

  // Only software-clearable bits take writes; the buffer bits are never stored.
  wire [7:0] pf_sw_mask = `MASK_PERIPHERAL_FLAGS_SW;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pflag
      assign pflags_nxt[g] = p_evt[g] ||
                             (pf_sw_mask[g] && (wr_pf ? wd[g] : pflags_r[g]));
    end
  endgenerate

  // Per-source pending, and the priority chosen for each.
  wire t0_p = ctl_r[`BIT_T0_FLAG] && ctl_r[`BIT_T0_ENABLE];
  wire e0_p = ctl_r[`BIT_EXT0_FLAG] && ctl_r[`BIT_EXT0_ENABLE];
  wire pc_p = ctl_r[`BIT_PORT_CHANGE_FLAG] && ctl_r[`BIT_PORT_CHANGE_ENABLE];
  wire e1_p = ctl3_r[`BIT_EXT1_FLAG] && ctl3_r[`BIT_EXT1_ENABLE];
  wire e2_p = ctl3_r[`BIT_EXT2_FLAG] && ctl3_r[`BIT_EXT2_ENABLE];
  wire [7:0] per_p = pf_live & pen_r;
  wire t0_hi = t0_p && ctl2_r[`BIT_T0_PRIORITY];
  wire pc_hi = pc_p && ctl2_r[`BIT_PORT_CHANGE_PRIORITY];
  wire e1_hi = e1_p && ctl3_r[`BIT_EXT1_PRIORITY];
  wire e2_hi = e2_p && ctl3_r[`BIT_EXT2_PRIORITY];
  // Pin 0 has no priority bit, so it always counts as high priority.
  wire core_hi = t0_hi || e0_p || pc_hi || e1_hi || e2_hi;
  wire core_lo = (t0_p && !t0_hi) || (pc_p && !pc_hi) ||
                 (e1_p && !e1_hi) || (e2_p && !e2_hi);
  wire per_hi = |(per_p & pprio_r);
  wire per_lo = |(per_p & ~pprio_r);
  wire gh = ctl_r[`BIT_GLOBAL_OR_HIGH];
  wire gl = ctl_r[`BIT_PERIPH_OR_LOW];
  wire any_core = t0_p || e0_p || pc_p || e1_p || e2_p;
  // Compatibility mode ignores priority bits entirely.
  wire req_compat = gh && (any_core || (gl && |per_p));
  wire req_high = gh && (core_hi || per_hi);
  // Low requests wait while any service runs, so a low never nests in a high.
  wire req_low = gl && (core_lo || per_lo) && (state_r != ST_SERVICE);
  wire take_high = priority_mode_enable_r ? req_high : req_compat;
  wire take_low = priority_mode_enable_r && req_low && !take_high;

  always @* begin
    addr_ok = 1'h1;
    rdata_nxt = 8'h00;
    case (paddr)
      `OFS_INTERRUPT_CONTROL: begin
        rdata_nxt = ctl_r;
      end
      `OFS_INTERRUPT_CONTROL_TWO: begin
        rdata_nxt = ctl2_r & `MASK_INTERRUPT_CONTROL_TWO;
      end
      `OFS_INTERRUPT_CONTROL_THREE: begin
        rdata_nxt = ctl3_r & `MASK_INTERRUPT_CONTROL_THREE;
      end
      `OFS_PERIPHERAL_FLAGS_ONE: begin
        rdata_nxt = pf_live;
      end
      `OFS_PERIPHERAL_ENABLES: begin
        rdata_nxt = pen_r;
      end
      `OFS_PERIPHERAL_PRIORITY: begin
        rdata_nxt = pprio_r;
      end
      `OFS_CORE_CONTROL: begin
        rdata_nxt = {priority_mode_enable_r, 7'h00};
      end
      default: begin
        addr_ok = 1'h0;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pready <= 1'h0;
      pslverr <= 1'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !addr_ok;
      if (setup && !pwrite) begin
        prdata <= {24'h000000, rdata_nxt};
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // Writes first, then hardware sets, then the core handshake; later lines win.
  always @* begin
    ctl_nxt = ctl_r;
    if (wr_ctl) begin
      ctl_nxt = wd;
    end
    if (timer0_overflow) begin
      ctl_nxt[`BIT_T0_FLAG] = 1'h1;
    end
    if (ext_evt[0]) begin
      ctl_nxt[`BIT_EXT0_FLAG] = 1'h1;
    end
    if (mismatch) begin
      ctl_nxt[`BIT_PORT_CHANGE_FLAG] = 1'h1;
    end
    if (drop_high) begin
      ctl_nxt[`BIT_GLOBAL_OR_HIGH] = 1'h0;
    end
    if (drop_low) begin
      ctl_nxt[`BIT_PERIPH_OR_LOW] = 1'h0;
    end
    if (raise_high) begin
      ctl_nxt[`BIT_GLOBAL_OR_HIGH] = 1'h1;
    end
    if (raise_low) begin
      ctl_nxt[`BIT_PERIPH_OR_LOW] = 1'h1;
    end
  end

  always @* begin
    ctl3_nxt = ctl3_r;
    if (wr_ctl3) begin
      ctl3_nxt = wd & `MASK_INTERRUPT_CONTROL_THREE;
    end
    if (ext_evt[1]) begin
      ctl3_nxt[`BIT_EXT1_FLAG] = 1'h1;
    end
    if (ext_evt[2]) begin
      ctl3_nxt[`BIT_EXT2_FLAG] = 1'h1;
    end
  end

  always @* begin
    state_nxt = state_r;
    serv_high_nxt = serv_high_r;
    irq_request_nxt = 1'h0;
    irq_vector_nxt = irq_vector;
    drop_high = 1'h0;
    drop_low = 1'h0;
    raise_high = 1'h0;
    raise_low = 1'h0;
    case (state_r)
      ST_IDLE: begin
        if (take_high || take_low) begin
          irq_request_nxt = 1'h1;
          irq_vector_nxt = take_low ? `VECTOR_LOW : `VECTOR_HIGH;
          if (irq_ack) begin
            serv_high_nxt = !take_low;
            state_nxt = ST_SERVICE;
            drop_low = take_low;
            drop_high = !take_low;
          end
        end
      end
      ST_SERVICE: begin
        // A high-priority source may still preempt a low-priority service.
        if (!serv_high_r && take_high) begin
          irq_request_nxt = 1'h1;
          irq_vector_nxt = `VECTOR_HIGH;
          if (irq_ack) begin
            serv_high_nxt = 1'h1;
            drop_high = 1'h1;
          end
        end else if (irq_return) begin
          state_nxt = ST_IDLE;
          raise_high = serv_high_r || !priority_mode_enable_r;
          raise_low = !(serv_high_r || !priority_mode_enable_r);
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl_r <= `RST_INTERRUPT_CONTROL;
      ctl2_r <= `RST_INTERRUPT_CONTROL_TWO;
      ctl3_r <= `RST_INTERRUPT_CONTROL_THREE;
      pflags_r <= `RST_PERIPHERAL_FLAGS_ONE;
    end else begin
      ctl_r <= ctl_nxt;
      if (wr_ctl2) begin
        ctl2_r <= wd & `MASK_INTERRUPT_CONTROL_TWO;
      end
      ctl3_r <= ctl3_nxt;
      pflags_r <= pflags_nxt;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pen_r <= `RST_PERIPHERAL_ENABLES;
      pprio_r <= `RST_PERIPHERAL_PRIORITY;
      priority_mode_enable_r <= 1'h0;
    end else begin
      if (wr_pen) begin
        pen_r <= wd;
      end
      if (wr_pprio) begin
        pprio_r <= wd;
      end
      if (wr_core) begin
        priority_mode_enable_r <= wd[`BIT_PRIORITY_MODE];
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ext_prev_r <= 3'h0;
      port_snap_r <= 4'h0;
    end else begin
      ext_prev_r <= ext_pins;
      if (port_b_data_read) begin
        port_snap_r <= upper_port_pins;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= ST_IDLE;
      serv_high_r <= 1'h0;
      irq_request <= 1'h0;
      irq_vector <= `VECTOR_HIGH;
    end else begin
      state_r <= state_nxt;
      serv_high_r <= serv_high_nxt;
      irq_request <= irq_request_nxt;
      irq_vector <= irq_vector_nxt;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      port_b_pullup_en <= 8'h00;
    end else begin
      if (ctl2_r[`BIT_PULLUP_DISABLE]) begin
        port_b_pullup_en <= 8'h00;
      end else begin
        port_b_pullup_en <= port_b_latch;
      end
    end
  end

endmodule // interrupt_enable_flag_priority

// ==== tb/irq_core_model.sv ====
// Purpose: Behavioural core that takes interrupt requests and later returns from them.
// Assumes: The block samples irq_ack while irq_request is high.
// Notes: The return follows a fixed gap, so software has a service window to clear flags.
`timescale 1ns/100ps
module irq_core_model #(parameter logic [4:0] RET_GAP = 5'h10) (
  input logic clk,
  input logic rst,
  input logic irq_request,
  input logic [23:0] irq_vector,
  input logic [3:0] ack_wait,
  output logic irq_ack,
  output logic irq_return,
  output logic [23:0] taken_vector,
  output logic [7:0] n_taken
);
  logic [3:0] wait_cnt;
  logic [4:0] ret_cnt;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {irq_ack, irq_return, taken_vector, n_taken, wait_cnt, ret_cnt} <= '0;
    end else begin
      irq_ack <= 1'b0;
      irq_return <= 1'b0;
      if (ret_cnt != 5'h0) begin
        ret_cnt <= ret_cnt - 5'h1;
        irq_return <= (ret_cnt == 5'h1);
      end else if (irq_request && wait_cnt == ack_wait) begin
        irq_ack <= 1'b1;
        taken_vector <= irq_vector;
        n_taken <= n_taken + 8'h1;
        wait_cnt <= 4'h0;
        ret_cnt <= RET_GAP;
      end else begin
        wait_cnt <= irq_request ? wait_cnt + 4'h1 : 4'h0;
      end
    end
  end
endmodule // irq_core_model

// ==== tb/interrupt_enable_flag_priority_sva.sv ====
// Purpose: Port-level checks for the interrupt control block.
// Assumes: Zero-wait APB slave with registered outputs.
// Notes: Flag state is only visible through reads, so checks lean on read data.
`timescale 1ns/100ps
module irq_ctrl_sva (
  input logic clk,
  input logic rst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic receive_buffer_full,
  input logic transmit_buffer_empty,
  input logic irq_ack,
  input logic irq_request,
  input logic [23:0] irq_vector,
  input logic [7:0] port_b_latch,
  input logic [7:0] port_b_pullup_en
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_ready; psel && !penable |=> pready && penable; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_decode; pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h18); endproperty
  a_decode: assert property (p_decode) else $error("bad address decode");
  property p_ack; irq_ack && irq_request |=> ##[0:1] !irq_request; endproperty
  a_ack: assert property (p_ack) else $error("request kept after ack");
  property p_vec; irq_request |-> irq_vector == 24'h000008 || irq_vector == 24'h000018;
  endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_pull; port_b_pullup_en != 8'h00 |-> port_b_pullup_en == $past(port_b_latch);
  endproperty
  a_pull: assert property (p_pull) else $error("pull-ups differ from latch");
  property p_gap2; pready && !pwrite && paddr == 8'h04 |-> !prdata[3] && !prdata[1];
  endproperty
  a_gap2: assert property (p_gap2) else $error("gap bit set");
  property p_gap3; pready && !pwrite && paddr == 8'h08 |-> !prdata[5] && !prdata[2];
  endproperty
  a_gap3: assert property (p_gap3) else $error("gap bit set");
  property p_live; pready && !pwrite && paddr == 8'h0c
    |-> prdata[5:4] == $past({receive_buffer_full, transmit_buffer_empty});
  endproperty
  a_live: assert property (p_live) else $error("buffer flags wrong");
  c_low: cover property (irq_ack && irq_vector == 24'h000018);
  c_err: cover property (pslverr);
  c_pull: cover property (port_b_pullup_en != 8'h00);
endmodule // irq_ctrl_sva
bind interrupt_enable_flag_priority irq_ctrl_sva irq_ctrl_sva_inst (.clk, .rst, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .receive_buffer_full,
  .transmit_buffer_empty, .irq_ack, .irq_request, .irq_vector, .port_b_latch,
  .port_b_pullup_en);

// ==== tb/interrupt_enable_flag_priority_tb_top.sv ====
// Purpose: Self-checking bench for the interrupt control block.
// Assumes: Zero-wait APB slave; the core model acknowledges requests.
// Notes: Flags are seen by register reads, never by peeking inside.
`timescale 1ns/100ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module interrupt_enable_flag_priority_tb_top;
  logic clk = '0;
  logic rst = '1;
  logic psel = '0;
  logic penable = '0;
  logic pwrite = '0;
  logic capture_compare_pwm_mode = '0;
  logic small_package = '0;
  logic receive_buffer_full = '0;
  logic transmit_buffer_empty = '0;
  logic [7:0] paddr = '0;
  logic [7:0] port_b_latch = 8'ha5;
  logic [7:0] ev = '0;
  logic [7:0] k;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rdat;
  logic pready, pslverr, rerr, irq_ack, irq_return, irq_request;
  logic [2:0] ext_pins = '0;
  logic [3:0] upper_port_pins = '0;
  logic [3:0] ack_wait = '0;
  logic [23:0] irq_vector, taken_vector;
  logic [7:0] port_b_pullup_en, n_taken;
  logic [7:0] rst_val [7] = '{8'h00, 8'hf5, 8'hc0, 8'h00, 8'h00, 8'hff, 8'h00};
  int n_fail = 0;
  int n_tests = 0;
  int cyc_cnt = 0;
  wire timer0_overflow, timer1_overflow, conversion_done, sync_serial_done;
  wire capture_compare_event, timer2_match, parallel_port_done, port_b_data_read;
  assign {timer0_overflow, timer1_overflow, conversion_done, sync_serial_done,
    capture_compare_event, timer2_match, parallel_port_done, port_b_data_read} = ev;
  always #25 clk = ~clk;
  interrupt_enable_flag_priority interrupt_enable_flag_priority_inst (.*);
  irq_core_model irq_core_model_inst (.*);
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, d};
    @(posedge clk) penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rdat[7:0], e)
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 8'h00;
  endtask
  task automatic irq_case(input logic [7:0] c, m, input logic [23:0] v,
    input logic [7:0] after, back);
    k = n_taken + 8'h1;
    wr(8'h00, c);
    pulse(m);
    for (int i = 0; i < 40 && n_taken !== k; i++) @(posedge clk);
    `CHK(n_taken, k)
    `CHK(taken_vector, v)
    rc(8'h00, after);
    wr(8'h00, after & 8'hf8);
    wr(8'h0c, 8'h00);
    repeat (16) @(posedge clk);
    rc(8'h00, back);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // A hang anywhere ends the run as a failure.
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    foreach (rst_val[i]) rc(8'(i * 4), rst_val[i]);
    xfer(1'b0, 8'h1c, 32'h0);
    `CHK({rerr, rdat}, 33'h100000000)
    wr(8'h04, 8'hff);
    rc(8'h04, 8'hf5);
    wr(8'h08, 8'hff);
    rc(8'h08, 8'hdb);
    wr(8'h08, 8'hc0);
    `CHK(port_b_pullup_en, 8'h00)
    wr(8'h04, 8'h75);
    repeat (2) @(posedge clk);
    `CHK(port_b_pullup_en, 8'ha5)
    wr(8'h04, 8'hf5);
    pulse(8'h80);
    rc(8'h00, 8'h04);
    wr(8'h00, 8'h00);
    @(posedge clk) ext_pins <= 3'h7;
    rc(8'h00, 8'h02);
    rc(8'h08, 8'hc3);
    wr(8'h00, 8'h00);
    wr(8'h08, 8'hc0);
    wr(8'h04, 8'h85);
    @(posedge clk) ext_pins <= 3'h0;
    rc(8'h00, 8'h02);
    rc(8'h08, 8'hc3);
    wr(8'h00, 8'h00);
    wr(8'h08, 8'hc0);
    wr(8'h04, 8'hf5);
    @(posedge clk) upper_port_pins <= 4'h9;
    wr(8'h00, 8'h00);
    rc(8'h00, 8'h01);
    pulse(8'h01);
    wr(8'h00, 8'h00);
    rc(8'h00, 8'h00);
    pulse(8'h7e);
    rc(8'h0c, 8'hcf);
    wr(8'h0c, 8'h00);
    @(posedge clk) {capture_compare_pwm_mode, small_package} <= 2'h3;
    pulse(8'h0a);
    rc(8'h0c, 8'h00);
    @(posedge clk) {capture_compare_pwm_mode, small_package} <= 2'h0;
    @(posedge clk) {receive_buffer_full, transmit_buffer_empty} <= 2'h3;
    wr(8'h0c, 8'h00);
    rc(8'h0c, 8'h30);
    @(posedge clk) {receive_buffer_full, transmit_buffer_empty} <= 2'h0;
    rc(8'h0c, 8'h00);
    `CHK(n_taken, 8'h00)
    irq_case(8'ha0, 8'h80, 24'h000008, 8'h24, 8'ha0);
    wr(8'h10, 8'h01);
    wr(8'h00, 8'h80);
    pulse(8'h40);
    repeat (6) @(posedge clk);
    `CHK(n_taken, 8'h01)
    irq_case(8'hc0, 8'h40, 24'h000008, 8'h40, 8'hc0);
    ack_wait <= 4'h3;
    wr(8'h18, 8'h80);
    wr(8'h14, 8'hfe);
    irq_case(8'h40, 8'h40, 24'h000018, 8'h00, 8'h40);
    irq_case(8'ha0, 8'h80, 24'h000008, 8'h24, 8'ha0);
    print_verdict;
  end
endmodule // interrupt_enable_flag_priority_tb_top
